// >>> dv/fmp_ctrl_properties.sv
// Port-level checker for the flyback mode and protection controller
module fmp_ctrl_chk
  import fmp_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Bus handshake
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // Comparators
  input wire logic       feedback_below_burst_entry,
  input wire logic       feedback_above_burst_exit,
  input wire logic       current_limit_reached,
  input wire logic       sense_below_valley,
  // Controls
  input wire logic       startup_source_en,
  input wire logic       gate_request,
  input wire logic [7:0] peak_limit_ref,
  input wire logic       bias_enable,
  input wire logic       extra_phase_current,
  input wire logic       low_current_phase,
  input wire logic       high_current_phase,
  input wire logic       ovp_phase,
  input wire logic       valley_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************
  // Helper counters
  // ****************
  logic [7:0] on_q, lim_q, brst_q;
  wire        brst_in = feedback_below_burst_entry & ~feedback_above_burst_exit;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      on_q   <= 8'h00;
      lim_q  <= 8'h00;
      brst_q <= 8'h00;
    end else begin
      on_q   <= gate_request ? on_q + {7'h00, on_q != 8'hFF} : 8'h00;
      lim_q  <= current_limit_reached ? lim_q + {7'h00, lim_q != 8'hFF} : 8'h00;
      brst_q <= brst_in ? brst_q + {7'h00, brst_q != 8'hFF} : 8'h00;
    end
  end
  // ****************
  // Assertions
  // ****************
  a_ramp_from_zero: assert property ($fell(startup_source_en) |-> peak_limit_ref == 8'h00)
    else $error("ramp not at zero");
  a_ref_step: assert property ((peak_limit_ref != $past(peak_limit_ref)) |->
    (peak_limit_ref == $past(peak_limit_ref) + 8'h01) || (peak_limit_ref == 8'h00))
    else $error("reference jumped");
  a_blank_hold: assert property (($rose(gate_request) && !feedback_below_burst_entry) |->
    gate_request[*8]) else $error("on-time cut in blanking");
  a_limit_ends: assert property ((gate_request && on_q >= 8'd70 && lim_q >= 8'd4) |->
    ##[1:2] !gate_request) else $error("on-time not ended");
  a_phase_onehot: assert property ($onehot0({low_current_phase, high_current_phase, ovp_phase}))
    else $error("phases overlap");
  a_bias_phase: assert property (bias_enable == (low_current_phase || high_current_phase))
    else $error("bias mismatch");
  a_extra_high: assert property (extra_phase_current == high_current_phase)
    else $error("extra source mismatch");
  a_burst_hold: assert property ((brst_q >= 8'd4) |-> !$rose(gate_request))
    else $error("gate in burst");
  a_valley_cause: assert property ($rose(valley_flag) |-> ($past(sense_below_valley, 2) ||
    $past(sense_below_valley, 3) || $past(sense_below_valley, 4))) else $error("stray valley");
  a_apb_wait: assert property ((psel && penable && !pready) |=> pready)
    else $error("no bus answer");
  c_gate: cover property ($rose(gate_request));
  c_start: cover property ($fell(startup_source_en));
  c_ovp: cover property ($rose(ovp_phase));
  c_valley: cover property ($rose(valley_flag));
endmodule : fmp_ctrl_chk

bind fmp_ctrl fmp_ctrl_chk i_chk (
  .clk, .sys_rst, .psel, .penable, .pready, .feedback_below_burst_entry,
  .feedback_above_burst_exit, .current_limit_reached, .sense_below_valley, .startup_source_en,
  .gate_request, .peak_limit_ref, .bias_enable, .extra_phase_current, .low_current_phase,
  .high_current_phase, .ovp_phase, .valley_flag
);

// >>> dv/fmp_ctrl_test.sv
// Self-checking testbench for the flyback mode and protection controller
module fmp_ctrl_test
  import fmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SS_SIM = 512;
  localparam int MID    = 256 * 256 / SS_SIM;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, g_d, er;
  logic [7:0]  paddr, peak_limit_ref;
  logic [31:0] pwdata, prdata, rd;
  logic        supply_above_release, supply_below_lockout, supply_over_voltage;
  logic        over_current_fault, feedback_above_power_limit, feedback_above_peak;
  logic        feedback_below_burst_entry, feedback_above_burst_exit, feedback_below_green;
  logic        current_limit_reached, sense_below_valley, otp_diff_below_limit;
  logic        ovp_current_above_limit, startup_source_en, gate_request, bias_enable;
  logic        extra_phase_current, low_current_phase, high_current_phase, ovp_phase;
  logic        sample_low_hold, sample_high_hold, valley_flag, ovp_hi, otp_hot;
  logic [9:0]  on_len;
  int          failures = 0, n_tests = 0, cyc = 0, vcnt = 0, rcnt = 0, p, q;
  int          seed = 32'h21a7;
  wire         rise = gate_request & ~g_d;

  fmp_ctrl #(.SS_CYCLES(SS_SIM), .OLP_CYCLES(100)) i_dut (
    .clk, .sys_rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .supply_above_release, .supply_below_lockout, .supply_over_voltage,
    .over_current_fault, .feedback_below_burst_entry, .feedback_above_burst_exit,
    .feedback_above_peak, .feedback_below_green, .feedback_above_power_limit,
    .current_limit_reached, .sense_below_valley, .otp_diff_below_limit,
    .ovp_current_above_limit, .startup_source_en, .gate_request, .peak_limit_ref,
    .bias_enable, .extra_phase_current, .low_current_phase, .high_current_phase,
    .ovp_phase, .sample_low_hold, .sample_high_hold, .valley_flag
  );
  fmp_plant i_plant (
    .clk, .gate_request, .ovp_phase, .on_len, .ovp_hi, .otp_hot, .current_limit_reached,
    .sense_below_valley, .ovp_current_above_limit, .otp_diff_below_limit
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    g_d <= gate_request;
    vcnt += int'(valley_flag === 1'b1);
    rcnt += int'(rise === 1'b1);
    if (cyc == 99000) begin
      failures++;
      end_sim();
    end
  end

  task end_sim;
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task wg;
    do @(posedge clk); while (rise !== 1'b1);
  endtask : wg
  task per(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (rise !== 1'b1);
    otp_hot <= 1'($random(seed));
  endtask : per
  task ont(output int c);
    wg();
    c = 0;
    while (gate_request === 1'b1) begin
      @(posedge clk);
      c++;
    end
  endtask : ont
  task start;
    do @(posedge clk); while (startup_source_en !== 1'b0);
    chk(32'(peak_limit_ref), 0);
    w(256);
    chk(32'(peak_limit_ref > MID - 4 && peak_limit_ref < MID + 3), 1);
    w(SS_SIM);
    chk(32'(peak_limit_ref), REF_MAX);
  endtask : start
  task recover;
    apb(1'b1, FAULT_OFS, 32'h0000_001F);
    supply_above_release <= 1'b0;
    supply_below_lockout <= 1'b1;
    w(8);
    chk(32'(startup_source_en), 1);
    supply_below_lockout <= 1'b0;
    supply_above_release <= 1'b1;
    start();
  endtask : recover

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {supply_above_release, supply_below_lockout, supply_over_voltage, over_current_fault} = '0;
    {feedback_above_power_limit, feedback_above_peak, feedback_below_burst_entry} = '0;
    {feedback_above_burst_exit, feedback_below_green, ovp_hi, otp_hot} = 4'h8;
    on_len = 10'd200;
    sys_rst = 1'b1;
    w(5);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(32'(startup_source_en), 1);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, CTRL_RST);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(er), 1);
    apb(1'b1, REF_OFS, 32'hFF);
    apb(1'b0, REF_OFS, 32'h0);
    chk(rd, 0);
    supply_above_release <= 1'b1;
    start();
    wg();
    per(p);
    chk(p, NOM_PERIOD_CYC);
    chk(32'(vcnt > 0), 1);
    apb(1'b1, CTRL_OFS, 32'h3);
    wg();
    per(p);
    per(q);
    chk(32'(p != q && p <= NOM_PERIOD_CYC + SHUFFLE_AMP_CYC && p >= NOM_PERIOD_CYC - SHUFFLE_AMP_CYC), 1);
    apb(1'b1, CTRL_OFS, 32'h1);
    feedback_below_green <= 1'b1;
    wg();
    per(p);
    per(q);
    chk(32'(q - p), LIGHT_STEP_CYC);
    feedback_below_green <= 1'b0;
    feedback_above_peak <= 1'b1;
    wg();
    per(p);
    per(q);
    chk(q, PK_PERIOD_CYC);
    on_len <= 10'(100 + ($random(seed) & 255));
    ont(p);
    chk(32'(p >= on_len && p <= on_len + 6), 1);
    on_len <= 10'd5;
    ont(p);
    chk(32'(p >= BLANK_CYC - 2 && p <= BLANK_CYC + 6), 1);
    on_len <= 10'd200;
    feedback_below_burst_entry <= 1'b1;
    feedback_above_burst_exit <= 1'b0;
    w(10);
    q = rcnt;
    w(2500);
    chk(rcnt - q, 0);
    feedback_below_burst_entry <= 1'b0;
    q = rcnt;
    w(2500);
    chk(rcnt - q, 0);
    feedback_above_burst_exit <= 1'b1;
    q = rcnt;
    w(2500);
    chk(32'(rcnt > q), 1);
    ovp_hi <= 1'b1;
    repeat (4) wg();
    ovp_hi <= 1'b0;
    wg();
    apb(1'b0, FAULT_OFS, 32'h0);
    chk(32'(rd[FLT_OVP_BIT]), 0);
    ovp_hi <= 1'b1;
    w(7 * PK_PERIOD_CYC);
    apb(1'b0, FAULT_OFS, 32'h0);
    chk(32'(rd[FLT_OVP_BIT]), 1);
    ovp_hi <= 1'b0;
    q = rcnt;
    w(3000);
    chk(rcnt - q, 0);
    recover();
    for (int i = 0; i < 3; i++) begin
      {supply_over_voltage, over_current_fault, feedback_above_power_limit} <= 3'(1 << i);
      w(300);
      {supply_over_voltage, over_current_fault, feedback_above_power_limit} <= 3'h0;
      apb(1'b0, FAULT_OFS, 32'h0);
      chk(32'(rd[FLT_OLP_BIT + i]), 1);
      recover();
    end
    end_sim();
  end
endmodule : fmp_ctrl_test

// >>> dv/fmp_plant.sv
// Model of the power switch, transformer and sense network
module fmp_plant (
  // Clock
  input  wire logic       clk,
  // Controller side
  input  wire logic       gate_request,
  input  wire logic       ovp_phase,
  // Scenario knobs
  input  wire logic [9:0] on_len,
  input  wire logic       ovp_hi,
  input  wire logic       otp_hot,
  // Comparator outputs
  output logic            current_limit_reached,
  output logic            sense_below_valley,
  output logic            ovp_current_above_limit,
  output logic            otp_diff_below_limit
);
  timeunit 1ns;
  timeprecision 100ps;
  int on_cnt = 0;
  int off_cnt = 0;
  always @(posedge clk) begin
    on_cnt <= gate_request ? on_cnt + 1 : 0;
    off_cnt <= gate_request ? 0 : off_cnt + 1;
  end
  // Primary current ramps until it meets the feedback level
  assign current_limit_reached = gate_request && on_cnt >= int'(on_len);
  // Ringing after demagnetisation dips briefly below the valley level
  assign sense_below_valley = off_cnt >= 300 && off_cnt < 304;
  assign ovp_current_above_limit = ovp_phase && ovp_hi;
  assign otp_diff_below_limit = otp_hot;
endmodule : fmp_plant

// >>> pkg/fmp_pkg.sv
// Constants and types for the flyback mode and protection controller
package fmp_pkg;

  // ****************
  // Clock and timing
  // ****************
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned NOM_FREQ_HZ     = 65_000;
  localparam int unsigned PK_FREQ_HZ      = 125_000;
  localparam int unsigned NOM_PERIOD_CYC  = CLK_HZ / NOM_FREQ_HZ;
  localparam int unsigned PK_PERIOD_CYC   = CLK_HZ / PK_FREQ_HZ;
  localparam int unsigned LIGHT_STEP_CYC  = 4;
  localparam int unsigned LIGHT_MAX_CYC   = 2 * NOM_PERIOD_CYC;
  localparam int unsigned SHUFFLE_PCT     = 7;
  localparam int unsigned SHUFFLE_AMP_CYC = NOM_PERIOD_CYC * SHUFFLE_PCT / 100;
  localparam int unsigned BLANK_TIME_NS   = 250;
  localparam int unsigned BLANK_CYC       = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SS_TIME_NS      = 2_500_000;
  localparam int unsigned SS_CYC          = SS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned OLP_TIME_NS     = 40_000_000;
  localparam int unsigned OLP_CYC         = OLP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned PHASE_CYC       = 64;
  localparam int unsigned OTP_DEBOUNCE    = 30;
  localparam int unsigned OVP_DEBOUNCE    = 5;
  localparam int unsigned REF_MAX         = 255;

  // ****************
  // Register map
  // ****************
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STATUS_OFS      = 8'h04;
  localparam logic [7:0]  FAULT_OFS       = 8'h08;
  localparam logic [7:0]  REF_OFS         = 8'h0C;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0001;
  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam int unsigned CTRL_SHUF_BIT   = 1;
  localparam int unsigned FLT_OTP_BIT     = 0;
  localparam int unsigned FLT_OVP_BIT     = 1;
  localparam int unsigned FLT_OLP_BIT     = 2;
  localparam int unsigned FLT_OCP_BIT     = 3;
  localparam int unsigned FLT_VDD_BIT     = 4;

  // ****************
  // States
  // ****************
  typedef enum logic [1:0] {
    ST_CHARGE = 2'b00,
    ST_RUN    = 2'b01,
    ST_FAULT  = 2'b10
  } fmp_state_e;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b10,
    PH_OVP  = 2'b11
  } fmp_phase_e;

endpackage : fmp_pkg

// >>> rtl/fmp_ctrl.sv
// Flyback mode, soft start and protection controller with APB registers
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
module fmp_ctrl
  import fmp_pkg::*;
#(
  parameter int unsigned SS_CYCLES  = SS_CYC,
  parameter int unsigned OLP_CYCLES = OLP_CYC
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog comparator inputs
  input  wire logic        supply_above_release,
  input  wire logic        supply_below_lockout,
  input  wire logic        supply_over_voltage,
  input  wire logic        over_current_fault,
  input  wire logic        feedback_below_burst_entry,
  input  wire logic        feedback_above_burst_exit,
  input  wire logic        feedback_above_peak,
  input  wire logic        feedback_below_green,
  input  wire logic        feedback_above_power_limit,
  input  wire logic        current_limit_reached,
  input  wire logic        sense_below_valley,
  input  wire logic        otp_diff_below_limit,
  input  wire logic        ovp_current_above_limit,
  // Analog controls
  output logic             startup_source_en,
  output logic             gate_request,
  output logic [7:0]       peak_limit_ref,
  output logic             bias_enable,
  output logic             extra_phase_current,
  output logic             low_current_phase,
  output logic             high_current_phase,
  output logic             ovp_phase,
  output logic             sample_low_hold,
  output logic             sample_high_hold,
  output logic             valley_flag
);

  // ****************
  // Input synchronisers
  // ****************
  localparam int unsigned NIN = 13;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;

  assign raw_in = {supply_above_release, supply_below_lockout, supply_over_voltage,
                   over_current_fault, feedback_below_burst_entry, feedback_above_burst_exit,
                   feedback_above_peak, feedback_below_green, feedback_above_power_limit,
                   current_limit_reached, sense_below_valley, otp_diff_below_limit,
                   ovp_current_above_limit};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce) begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  logic s_release, s_lockout, s_vdd_ovp, s_ocp, s_burst_in, s_burst_out, s_peak;
  logic s_green, s_plimit, s_climit, s_valley, s_otp_low, s_ovp_hi;
  assign {s_release, s_lockout, s_vdd_ovp, s_ocp, s_burst_in, s_burst_out, s_peak,
          s_green, s_plimit, s_climit, s_valley, s_otp_low, s_ovp_hi} = sync2_q;

  // ****************
  // Registers
  // ****************
  logic [31:0] ctrl_q;
  logic [4:0]  fault_q;
  logic [4:0]  fault_set;
  logic        apb_acc;
  logic        apb_wr;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  fmp_phase_e  phase_q;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == FAULT_OFS) || (a == REF_OFS);
  endfunction : mapped

  assign apb_acc = psel && penable && !pready_q;
  assign apb_wr  = psel && penable && pready_q && pwrite && mapped(paddr);

  // ****************
  // State machine
  // ****************
  fmp_state_e state_q;
  logic       fault_any;
  logic       start_run;

  assign fault_any = |fault_set;
  assign start_run = (state_q == ST_CHARGE) && s_release;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q           <= ST_CHARGE;
      startup_source_en <= 1'b1;
    end else if (ce) begin
      case (state_q)
        ST_CHARGE: begin
          if (s_release) begin
            state_q           <= ST_RUN;
            startup_source_en <= 1'b0;
          end
        end
        ST_RUN: begin
          if (fault_any) begin
            state_q <= ST_FAULT;
          end
        end
        ST_FAULT: begin
          if (s_lockout) begin
            state_q           <= ST_CHARGE;
            startup_source_en <= 1'b1;
          end
        end
        default: begin
          state_q           <= ST_CHARGE;
          startup_source_en <= 1'b1;
        end
      endcase
    end
  end

  // ****************
  // Soft start ramp
  // ****************
  localparam int unsigned SS_STEP = (SS_CYCLES / (REF_MAX + 1) > 0) ?
                                    SS_CYCLES / (REF_MAX + 1) : 1;
  logic [31:0] ss_cnt_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ss_cnt_q       <= '0;
      peak_limit_ref <= '0;
    end else if (ce) begin
      if (state_q != ST_RUN || start_run) begin
        ss_cnt_q       <= '0;
        peak_limit_ref <= '0;
      end else if (peak_limit_ref != 8'(REF_MAX)) begin
        if (ss_cnt_q == 32'(SS_STEP - 1)) begin
          ss_cnt_q       <= '0;
          peak_limit_ref <= peak_limit_ref + 8'h01;
        end else begin
          ss_cnt_q <= ss_cnt_q + 32'h0000_0001;
        end
      end
    end
  end

  // ****************
  // Oscillator and mode
  // ****************
  logic [15:0] per_cnt_q;
  logic [15:0] period;
  logic [15:0] light_ext_q;
  logic [15:0] shuf_q;
  logic        shuf_up_q;
  logic        cyc_end;
  logic        burst_q;

  assign cyc_end = (per_cnt_q >= period - 16'h0001);

  always_comb begin
    if (s_peak) begin
      period = 16'(PK_PERIOD_CYC);
    end else begin
      period = 16'(NOM_PERIOD_CYC) + light_ext_q;
      if (ctrl_q[CTRL_SHUF_BIT]) begin
        period = period + shuf_q - 16'(SHUFFLE_AMP_CYC);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt_q   <= '0;
      light_ext_q <= '0;
      shuf_q      <= 16'(SHUFFLE_AMP_CYC);
      shuf_up_q   <= 1'b1;
    end else if (ce) begin
      per_cnt_q <= cyc_end ? 16'h0000 : per_cnt_q + 16'h0001;
      if (cyc_end) begin
        if (s_green && !s_peak) begin
          if (light_ext_q < 16'(LIGHT_MAX_CYC - NOM_PERIOD_CYC)) begin
            light_ext_q <= light_ext_q + 16'(LIGHT_STEP_CYC);
          end
        end else if (light_ext_q != 16'h0000) begin
          light_ext_q <= light_ext_q - 16'(LIGHT_STEP_CYC);
        end
        if (shuf_up_q) begin
          shuf_q    <= shuf_q + 16'h0001;
          shuf_up_q <= (shuf_q < 16'(2 * SHUFFLE_AMP_CYC - 1));
        end else begin
          shuf_q    <= shuf_q - 16'h0001;
          shuf_up_q <= (shuf_q == 16'h0001);
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      burst_q <= 1'b0;
    end else if (ce) begin
      if (s_burst_in) begin
        burst_q <= 1'b1;
      end else if (s_burst_out) begin
        burst_q <= 1'b0;
      end
    end
  end

  // ****************
  // Gate and blanking
  // ****************
  logic [7:0] blank_q;
  logic       gate_on_ok;

  assign gate_on_ok = (state_q == ST_RUN) && !fault_any && ctrl_q[CTRL_EN_BIT]
                      && !burst_q && !s_burst_in && (peak_limit_ref != 8'h00);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gate_request <= 1'b0;
      blank_q      <= '0;
    end else if (ce) begin
      if (blank_q != 8'h00) begin
        blank_q <= blank_q - 8'h01;
      end
      if (!gate_on_ok) begin
        gate_request <= 1'b0;
      end else if (cyc_end) begin
        gate_request <= 1'b1;
        blank_q      <= 8'(BLANK_CYC);
      end else if (gate_request && s_climit && blank_q == 8'h00) begin
        gate_request <= 1'b0;
      end
    end
  end

  // ****************
  // Valley detection
  // ****************
  logic valley_d_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      valley_d_q  <= 1'b0;
      valley_flag <= 1'b0;
    end else if (ce) begin
      valley_d_q  <= s_valley;
      valley_flag <= s_valley && !valley_d_q && !gate_request && (phase_q == PH_IDLE);
    end
  end

  // ****************
  // Sense pin measurement phases
  // ****************
  logic [7:0] ph_cnt_q;
  logic       gate_fall;
  logic       gate_d_q;

  assign gate_fall = gate_d_q && !gate_request;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gate_d_q            <= 1'b0;
      phase_q             <= PH_IDLE;
      ph_cnt_q            <= '0;
      bias_enable         <= 1'b0;
      extra_phase_current <= 1'b0;
      low_current_phase   <= 1'b0;
      high_current_phase  <= 1'b0;
      ovp_phase           <= 1'b0;
      sample_low_hold     <= 1'b0;
      sample_high_hold    <= 1'b0;
    end else if (ce) begin
      gate_d_q         <= gate_request;
      sample_low_hold  <= 1'b0;
      sample_high_hold <= 1'b0;
      if (gate_request || state_q != ST_RUN) begin
        phase_q  <= PH_IDLE;
        ph_cnt_q <= '0;
      end else if (gate_fall) begin
        phase_q  <= PH_LOW;
        ph_cnt_q <= '0;
      end else if (phase_q != PH_IDLE) begin
        if (ph_cnt_q == 8'(PHASE_CYC - 1)) begin
          ph_cnt_q <= '0;
          case (phase_q)
            PH_LOW: begin
              phase_q         <= PH_HIGH;
              sample_low_hold <= 1'b1;
            end
            PH_HIGH: begin
              phase_q          <= PH_OVP;
              sample_high_hold <= 1'b1;
            end
            default: phase_q <= PH_IDLE;
          endcase
        end else begin
          ph_cnt_q <= ph_cnt_q + 8'h01;
        end
      end
      bias_enable         <= (phase_q == PH_LOW) || (phase_q == PH_HIGH);
      extra_phase_current <= (phase_q == PH_HIGH);
      low_current_phase   <= (phase_q == PH_LOW);
      high_current_phase  <= (phase_q == PH_HIGH);
      ovp_phase           <= (phase_q == PH_OVP);
    end
  end

  // ****************
  // Fault debounce (OCP and VDD over-voltage faults set without debounce)
  // ****************
  logic [4:0]  otp_cnt_q;
  logic [2:0]  ovp_cnt_q;
  logic [31:0] olp_cnt_q;
  logic        ph_last;

  assign ph_last = (ph_cnt_q == 8'(PHASE_CYC - 1));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      otp_cnt_q <= '0;
      ovp_cnt_q <= '0;
      olp_cnt_q <= '0;
    end else if (ce) begin
      if (state_q != ST_RUN) begin
        otp_cnt_q <= '0;
        ovp_cnt_q <= '0;
      end else begin
        if (phase_q == PH_OVP && ph_last) begin
          otp_cnt_q <= s_otp_low ? otp_cnt_q + 5'h01 : 5'h00;
        end
        if (phase_q == PH_OVP && ph_last) begin
          ovp_cnt_q <= s_ovp_hi ? ovp_cnt_q + 3'h1 : 3'h0;
        end
      end
      if (state_q == ST_RUN && s_plimit) begin
        olp_cnt_q <= olp_cnt_q + 32'h0000_0001;
      end else begin
        olp_cnt_q <= '0;
      end
    end
  end

  always_comb begin
    fault_set               = '0;
    fault_set[FLT_OTP_BIT]  = (otp_cnt_q >= 5'(OTP_DEBOUNCE));
    fault_set[FLT_OVP_BIT]  = (ovp_cnt_q >= 3'(OVP_DEBOUNCE));
    fault_set[FLT_OLP_BIT]  = (olp_cnt_q >= OLP_CYCLES);
    fault_set[FLT_OCP_BIT]  = (state_q == ST_RUN) && s_ocp;
    fault_set[FLT_VDD_BIT]  = (state_q == ST_RUN) && s_vdd_ovp;
  end

  // ****************
  // APB slave
  // ****************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q    <= CTRL_RST;
      fault_q   <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else if (ce) begin
      pready_q  <= apb_acc;
      pslverr_q <= apb_acc && !mapped(paddr);
      if (apb_wr && paddr == CTRL_OFS) begin
        ctrl_q <= {30'h0000_0000, pwdata[1:0]};
      end
      if (apb_wr && paddr == FAULT_OFS) begin
        fault_q <= (fault_q & ~pwdata[4:0]) | fault_set;
      end else begin
        fault_q <= fault_q | fault_set;
      end
      if (apb_acc) begin
        case (paddr)
          CTRL_OFS:   prdata_q <= ctrl_q;
          STATUS_OFS: prdata_q <= {24'h00_0000, phase_q, burst_q, s_peak, gate_request,
                                   startup_source_en, state_q};
          FAULT_OFS:  prdata_q <= {27'h000_0000, fault_q};
          REF_OFS:    prdata_q <= {24'h00_0000, peak_limit_ref};
          default:    prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule : fmp_ctrl
